// ===== rtl/ccp_pkg.sv
// constants and types shared by the capture/compare/pwm unit
package ccp_pkg;

    // register addresses on the plain register port
    localparam logic [3:0] ADDR_FIRST_CTRL = 4'h0;
    localparam logic [3:0] ADDR_FIRST_LOW = 4'h1;
    localparam logic [3:0] ADDR_FIRST_HIGH = 4'h2;
    localparam logic [3:0] ADDR_SECOND_CTRL = 4'h3;
    localparam logic [3:0] ADDR_SECOND_LOW = 4'h4;
    localparam logic [3:0] ADDR_SECOND_HIGH = 4'h5;
    localparam logic [3:0] ADDR_DEADBAND_RESTART = 4'h6;
    localparam logic [3:0] ADDR_SHUTDOWN_CONTROL = 4'h7;

    // module_control_reg field: mode in bits 2..0
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 2;

    // pwm_deadband_restart fields
    localparam int RESTART_BIT = 7;
    localparam int DEADBAND_MSB = 6;
    localparam int DEADBAND_LSB = 0;

    // pwm_shutdown_control fields
    localparam int STATUS_BIT = 7;
    localparam int SOURCE_MSB = 6;
    localparam int SOURCE_LSB = 4;
    localparam int PAIR_AC_MSB = 3;
    localparam int PAIR_AC_LSB = 2;
    localparam int PAIR_BD_MSB = 1;
    localparam int PAIR_BD_LSB = 0;

    // values after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] DEADBAND_RESTART_RESET = 8'h00;
    localparam logic [7:0] SHUTDOWN_CONTROL_RESET = 8'h00;
    localparam logic PIN_SELECT_RESET = 1'b1;

    // zero builds the small variant without dead-band count
    localparam logic HALF_BRIDGE_PRESENT = 1'b1;

    // one clk_i cycle is one instruction cycle (four oscillator periods)
    localparam int INSTR_CYCLE_CLOCKS = 1;

    // operating modes of one module
    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_CAPTURE_RISE = 3'b001,
        MODE_CAPTURE_FALL = 3'b010,
        MODE_COMPARE_TOGGLE = 3'b011,
        MODE_COMPARE_SPECIAL = 3'b100,
        MODE_PWM_SINGLE = 3'b101,
        MODE_PWM_HALF = 3'b110
    } mode_t;

    // shutdown drive state of a pin pair
    localparam logic [1:0] SHUT_DRIVE_LOW = 2'b00;
    localparam logic [1:0] SHUT_DRIVE_HIGH = 2'b01;

endpackage

// ===== rtl/ccp_unit.sv
// two capture/compare/pwm modules with enhanced pwm dead band and shutdown
//
// Summary of operation
// - capture/compare use first timer, pwm second timer
// - no capture while first timer counts asynchronously
// - pin select 1 primary pin, 0 alternate
// - compare special event resets the first timer
// - second module special event starts conversion
// - both pwms share second timer period match
// - data value is two readable writable bytes
// - dead band delays only inactive-to-active edges
// - delay is 7-bit count of instruction cycles
// - small variant has no dead-band count field
// - shutdown acts only in enhanced pwm modes
// - three source bits; none selected disables shutdown
// - shutdown forces pin pairs at once, unclocked
// - hardware sets status bit; holds shutdown states
// - auto restart clears status when causes clear
// - status set at period start holds whole period
// - outputs resume only at next period start
// - status writes ignored while cause active
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module ccp_unit (
    input wire logic clk_i, // instruction-cycle clock
    input wire logic reset_i, // synchronous reset, active high
    input wire logic [3:0] reg_addr_i, // register address
    input wire logic [7:0] reg_wdata_i, // register write data
    input wire logic reg_wr_i, // write strobe
    input wire logic reg_rd_i, // read strobe
    output logic [7:0] reg_rdata_o, // read data, cycle after strobe
    input wire logic [15:0] first_timer_i, // first timer count
    input wire logic first_timer_async_i, // first timer async counter
    input wire logic [7:0] second_timer_i, // second timer count
    input wire logic second_timer_match_i, // second timer period match
    input wire logic second_module_pin_select_i, // strap, caught at reset
    input wire logic first_capture_pin_i, // first module capture pin
    input wire logic second_primary_pin_i, // primary pin input
    input wire logic second_alternate_pin_i, // alternate pin input
    input wire logic comparator1_i, // comparator 1 output
    input wire logic comparator2_i, // comparator 2 output
    input wire logic fault_input_n_i, // fault input, active low
    output logic first_timer_reset_o, // special event timer reset
    output logic adc_start_o, // conversion start pulse
    output logic primary_output_pin_o, // second module on primary pin
    output logic alternate_output_pin_o, // second module on alternate
    output logic pwm_out_a_o, // enhanced output a level
    output logic pwm_out_a_oe_n_o, // a driven while low
    output logic pwm_out_b_o, // enhanced output b level
    output logic pwm_out_b_oe_n_o, // b driven while low
    output logic pwm_out_c_o, // enhanced output c level
    output logic pwm_out_c_oe_n_o, // c driven while low
    output logic pwm_out_d_o, // enhanced output d level
    output logic pwm_out_d_oe_n_o // d driven while low
);

    // mode decoders used by both modules
    function automatic logic is_capture(input logic [2:0] m);
        is_capture = (m == ccp_pkg::MODE_CAPTURE_RISE) ||
                     (m == ccp_pkg::MODE_CAPTURE_FALL);
    endfunction

    function automatic logic is_compare(input logic [2:0] m);
        is_compare = (m == ccp_pkg::MODE_COMPARE_TOGGLE) ||
                     (m == ccp_pkg::MODE_COMPARE_SPECIAL);
    endfunction

    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m == ccp_pkg::MODE_PWM_SINGLE) ||
                 (m == ccp_pkg::MODE_PWM_HALF);
    endfunction

    logic [7:0] ctrl [2]; // module_control_reg per module
    logic [7:0] data_low [2]; // module_data_low_byte
    logic [7:0] data_high [2]; // module_data_high_byte
    logic [7:0] duty_act [2]; // duty latched at period start
    logic [2:0] mode [2]; // mode field per module
    logic capture_evt [2]; // capture edge seen
    logic compare_hit [2]; // first timer equals data value
    logic cmp_out [2]; // compare output level
    logic pwm_level [2]; // undelayed pwm level
    logic restart_en; // auto_restart_enable
    logic [6:0] deadband_count; // delay in instruction cycles
    logic status; // shutdown_status
    logic [2:0] source_sel; // shutdown_source_select
    logic [1:0] pair_ac; // shutdown_state_pair_ac
    logic [1:0] pair_bd; // shutdown_state_pair_bd
    logic pin_sel; // second_module_pin_select as caught
    logic strap_taken; // strap caught since reset
    logic [5:0] sync1, sync2, sync3; // three-stage pin synchronisers
    logic [5:0] filt; // settled pin levels
    logic [5:0] filt_d; // settled levels one cycle ago
    logic enh_mode; // enhanced module in a pwm mode
    logic cause_f; // filtered shutdown cause
    logic cause_raw; // unclocked shutdown cause
    logic hold; // shutdown held until period start
    logic force_out; // pins take shutdown states
    logic [1:0] want; // wanted active level of a and b
    logic [1:0] act; // delayed active level of a and b
    logic [6:0] db_cnt [2]; // dead band counters
    logic [6:0] delay_eff; // delay applied to rising edges
    logic [3:0] pin_q; // registered pin levels a..d
    logic [3:0] pin_oe_n_q; // registered enables a..d
    logic wr_status; // software writes shutdown control

    assign mode[0] = ctrl[0][ccp_pkg::MODE_MSB:ccp_pkg::MODE_LSB];
    assign mode[1] = ctrl[1][ccp_pkg::MODE_MSB:ccp_pkg::MODE_LSB];

    // catch the pin-select strap one edge after reset release
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_sel <= ccp_pkg::PIN_SELECT_RESET;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            pin_sel <= second_module_pin_select_i;
            strap_taken <= 1'b1;
        end
    end

    // pin synchronisers; a level counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            sync3 <= 6'h00;
            // match the cleared stages: no false edge, no fault after reset
            filt <= 6'h00;
            filt_d <= 6'h00;
        end else begin
            sync1 <= {~fault_input_n_i, comparator2_i, comparator1_i,
                      second_alternate_pin_i, second_primary_pin_i,
                      first_capture_pin_i};
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
            filt_d <= filt;
        end
    end

    // register writes; data bytes may be overwritten by capture
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl[0] <= ccp_pkg::CTRL_RESET;
            ctrl[1] <= ccp_pkg::CTRL_RESET;
            restart_en <= 1'b0;
            deadband_count <= 7'h00;
            source_sel <= 3'h0;
            pair_ac <= 2'h0;
            pair_bd <= 2'h0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ccp_pkg::ADDR_FIRST_CTRL: ctrl[0] <= reg_wdata_i;
                ccp_pkg::ADDR_SECOND_CTRL: begin
                    // half-bridge mode belongs to the enhanced module only
                    if (reg_wdata_i[2:0] != ccp_pkg::MODE_PWM_HALF) begin
                        ctrl[1] <= reg_wdata_i;
                    end
                end
                ccp_pkg::ADDR_DEADBAND_RESTART: begin
                    restart_en <= reg_wdata_i[ccp_pkg::RESTART_BIT];
                    if (ccp_pkg::HALF_BRIDGE_PRESENT) begin
                        deadband_count <= reg_wdata_i[6:0];
                    end
                end
                ccp_pkg::ADDR_SHUTDOWN_CONTROL: begin
                    source_sel <= reg_wdata_i[6:4];
                    pair_ac <= reg_wdata_i[3:2];
                    pair_bd <= reg_wdata_i[1:0];
                end
                default: ;
            endcase
        end
    end

    // per-module capture, compare and pwm machinery
    for (genvar i = 0; i < 2; i++) begin : g_mod
        logic lvl, lvl_d; // selected capture level now and before
        // second module listens on the pin that the strap selects
        assign lvl = (i == 0) ? filt[0] : (pin_sel ? filt[1] : filt[2]);
        assign lvl_d = (i == 0) ? filt_d[0] :
                       (pin_sel ? filt_d[1] : filt_d[2]);
        // capture only on a synchronously counting first timer
        assign capture_evt[i] = is_capture(mode[i]) &&
            !first_timer_async_i &&
            ((mode[i] == ccp_pkg::MODE_CAPTURE_RISE) ? (lvl && !lvl_d)
                                                     : (!lvl && lvl_d));
        assign compare_hit[i] = is_compare(mode[i]) &&
            (first_timer_i == {data_high[i], data_low[i]});
        assign pwm_level[i] = is_pwm(mode[i]) &&
            (second_timer_i < duty_act[i]);

        // data bytes: software writes, capture loads first timer
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                data_low[i] <= ccp_pkg::DATA_RESET;
                data_high[i] <= ccp_pkg::DATA_RESET;
            end else if (capture_evt[i]) begin
                data_low[i] <= first_timer_i[7:0];
                data_high[i] <= first_timer_i[15:8];
            end else if (reg_wr_i) begin
                if (reg_addr_i == 4'(3 * i + 1)) begin
                    data_low[i] <= reg_wdata_i;
                end
                if (reg_addr_i == 4'(3 * i + 2)) begin
                    data_high[i] <= reg_wdata_i;
                end
            end
        end

        // duty taken only on the shared period match
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                duty_act[i] <= 8'h00;
            end else if (second_timer_match_i) begin
                duty_act[i] <= data_low[i];
            end
        end

        // compare output toggles on each match in toggle mode
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                cmp_out[i] <= 1'b0;
            end else if (compare_hit[i] &&
                         mode[i] == ccp_pkg::MODE_COMPARE_TOGGLE) begin
                cmp_out[i] <= !cmp_out[i];
            end
        end
    end

    // special event: timer reset from either module, conversion from second
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            first_timer_reset_o <= 1'b0;
            adc_start_o <= 1'b0;
        end else begin
            first_timer_reset_o <=
                (compare_hit[0] && mode[0] == ccp_pkg::MODE_COMPARE_SPECIAL) ||
                (compare_hit[1] &&
                 mode[1] == ccp_pkg::MODE_COMPARE_SPECIAL);
            adc_start_o <= compare_hit[1] &&
                mode[1] == ccp_pkg::MODE_COMPARE_SPECIAL;
        end
    end

    // second module drives only the selected pin; direction is software's
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            primary_output_pin_o <= 1'b0;
            alternate_output_pin_o <= 1'b0;
        end else begin
            primary_output_pin_o <= pin_sel &&
                (cmp_out[1] || pwm_level[1]);
            alternate_output_pin_o <= !pin_sel &&
                (cmp_out[1] || pwm_level[1]);
        end
    end

    // shutdown causes; raw one reacts without a clock edge
    assign enh_mode = is_pwm(mode[0]);
    assign cause_f = enh_mode && |(source_sel & filt[5:3]);
    assign cause_raw = enh_mode && |(source_sel &
        {~fault_input_n_i, comparator2_i, comparator1_i});
    assign wr_status = reg_wr_i &&
        (reg_addr_i == ccp_pkg::ADDR_SHUTDOWN_CONTROL);

    // status bit: hardware set beats any clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            status <= 1'b0;
        end else if (cause_f) begin
            status <= 1'b1;
        end else if (restart_en && status) begin
            status <= 1'b0;
        end else if (wr_status) begin
            status <= reg_wdata_i[ccp_pkg::STATUS_BIT];
        end
    end

    // hold spans whole periods so a clear never resumes mid-period
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hold <= 1'b0;
        end else if (cause_f || status) begin
            hold <= 1'b1;
        end else if (second_timer_match_i) begin
            hold <= 1'b0;
        end
    end

    assign force_out = enh_mode && (hold || status || cause_raw);

    // dead band only in half-bridge mode; zero count means no delay
    assign delay_eff = (mode[0] == ccp_pkg::MODE_PWM_HALF) ?
        deadband_count : 7'h00;
    assign want[0] = pwm_level[0];
    assign want[1] = (mode[0] == ccp_pkg::MODE_PWM_HALF) && !pwm_level[0];

    for (genvar j = 0; j < 2; j++) begin : g_db
        // falling edge passes at once, rising waits out the count
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                act[j] <= 1'b0;
                db_cnt[j] <= 7'h00;
            end else if (!want[j]) begin
                act[j] <= 1'b0;
                db_cnt[j] <= 7'h00;
            end else if (!act[j]) begin
                if (db_cnt[j] >= delay_eff) begin
                    act[j] <= 1'b1;
                end else begin
                    db_cnt[j] <= db_cnt[j] + 7'h01;
                end
            end
        end
    end

    // registered normal drive of the enhanced pins
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_q <= 4'h0;
            pin_oe_n_q <= 4'hF;
        end else begin
            pin_q <= {1'b0, 1'b0, act[1], act[0] || cmp_out[0]};
            pin_oe_n_q <= enh_mode ? 4'h0 :
                {3'h7, !is_compare(mode[0])};
        end
    end

    // shutdown overrides the flops combinationally so it needs no edge;
    // a glitch on a source pin can therefore reach the pins
    always_comb begin
        pwm_out_a_o = pin_q[0];
        pwm_out_c_o = pin_q[2];
        pwm_out_b_o = pin_q[1];
        pwm_out_d_o = pin_q[3];
        pwm_out_a_oe_n_o = pin_oe_n_q[0];
        pwm_out_c_oe_n_o = pin_oe_n_q[2];
        pwm_out_b_oe_n_o = pin_oe_n_q[1];
        pwm_out_d_oe_n_o = pin_oe_n_q[3];
        if (force_out) begin
            pwm_out_a_o = (pair_ac == ccp_pkg::SHUT_DRIVE_HIGH);
            pwm_out_c_o = (pair_ac == ccp_pkg::SHUT_DRIVE_HIGH);
            pwm_out_b_o = (pair_bd == ccp_pkg::SHUT_DRIVE_HIGH);
            pwm_out_d_o = (pair_bd == ccp_pkg::SHUT_DRIVE_HIGH);
            pwm_out_a_oe_n_o = pair_ac[1];
            pwm_out_c_oe_n_o = pair_ac[1];
            pwm_out_b_oe_n_o = pair_bd[1];
            pwm_out_d_oe_n_o = pair_bd[1];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (reset_i || !reg_rd_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            case (reg_addr_i)
                ccp_pkg::ADDR_FIRST_CTRL: reg_rdata_o <= ctrl[0];
                ccp_pkg::ADDR_FIRST_LOW: reg_rdata_o <= data_low[0];
                ccp_pkg::ADDR_FIRST_HIGH: reg_rdata_o <= data_high[0];
                ccp_pkg::ADDR_SECOND_CTRL: reg_rdata_o <= ctrl[1];
                ccp_pkg::ADDR_SECOND_LOW: reg_rdata_o <= data_low[1];
                ccp_pkg::ADDR_SECOND_HIGH: reg_rdata_o <= data_high[1];
                ccp_pkg::ADDR_DEADBAND_RESTART:
                    reg_rdata_o <= {restart_en, deadband_count};
                ccp_pkg::ADDR_SHUTDOWN_CONTROL:
                    reg_rdata_o <= {status, source_sel, pair_ac, pair_bd};
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ---- checks ----
    sequence s_cause_then_status;
        cause_f ##1 status;
    endsequence

    property p_status_set;
        @(posedge clk_i) disable iff (reset_i)
        cause_f |-> s_cause_then_status;
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("status not set by shutdown cause");

    property p_write_ignored;
        @(posedge clk_i) disable iff (reset_i)
        (wr_status && cause_f) |=> status;
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("status write took effect during shutdown");

    property p_auto_clear;
        @(posedge clk_i) disable iff (reset_i)
        (restart_en && status && !cause_f) |=> !status;
    endproperty
    a_auto_clear: assert property (p_auto_clear)
        else $error("auto restart did not clear status");

    sequence s_period_held;
        hold [*1] ##0 !second_timer_match_i;
    endsequence

    property p_hold_period;
        @(posedge clk_i) disable iff (reset_i)
        (status && second_timer_match_i) |=> hold;
    endproperty
    a_hold_period: assert property (p_hold_period)
        else $error("shutdown not held through the period");

    property p_resume_at_period;
        @(posedge clk_i) disable iff (reset_i)
        $fell(hold) |-> $past(second_timer_match_i) && !$past(status);
    endproperty
    a_resume_at_period: assert property (p_resume_at_period)
        else $error("pwm resumed in mid-period");

    property p_fall_undelayed;
        @(posedge clk_i) disable iff (reset_i)
        !want[0] |=> !act[0];
    endproperty
    a_fall_undelayed: assert property (p_fall_undelayed)
        else $error("active-to-inactive edge was delayed");

    property p_rise_delay;
        @(posedge clk_i) disable iff (reset_i)
        $rose(act[1]) |-> $past(db_cnt[1]) >= $past(delay_eff);
    endproperty
    a_rise_delay: assert property (p_rise_delay)
        else $error("output went active before dead band ended");

    property p_zero_delay;
        @(posedge clk_i) disable iff (reset_i)
        (delay_eff == 7'h00 && want[0] && !act[0]) |=> act[0] || !want[0];
    endproperty
    a_zero_delay: assert property (p_zero_delay)
        else $error("zero dead band still delayed the edge");

    property p_no_async_capture;
        @(posedge clk_i) disable iff (reset_i)
        first_timer_async_i |-> !capture_evt[0] && !capture_evt[1];
    endproperty
    a_no_async_capture: assert property (p_no_async_capture)
        else $error("capture during asynchronous timer counting");

    property p_timer_reset;
        @(posedge clk_i) disable iff (reset_i)
        (compare_hit[1] && mode[1] == ccp_pkg::MODE_COMPARE_SPECIAL)
            |=> first_timer_reset_o && adc_start_o;
    endproperty
    a_timer_reset: assert property (p_timer_reset)
        else $error("special event did not reset timer or start adc");

    property p_shared_update;
        @(posedge clk_i) disable iff (reset_i)
        second_timer_match_i |=> duty_act[0] == $past(data_low[0]) &&
            duty_act[1] == $past(data_low[1]);
    endproperty
    a_shared_update: assert property (p_shared_update)
        else $error("duty not updated on shared period match");

    property p_pin_route;
        @(posedge clk_i) disable iff (reset_i)
        pin_sel |=> !alternate_output_pin_o;
    endproperty
    a_pin_route: assert property (p_pin_route)
        else $error("second module drove unselected pin");

    property p_idle_no_shutdown;
        @(posedge clk_i) disable iff (reset_i)
        !enh_mode |-> !force_out && !cause_f;
    endproperty
    a_idle_no_shutdown: assert property (p_idle_no_shutdown)
        else $error("shutdown acted outside enhanced pwm mode");

endmodule

// ===== tb/bridge_partner.sv
// far-side model: comparators and fault input of the bridge
`timescale 1ns/1ps
module bridge_partner (
    input wire logic clk_i, // bench clock
    input wire logic [2:0] cause_i, // causes the bench asks for
    output logic comparator1_o, // comparator 1 tripped
    output logic comparator2_o, // comparator 2 tripped
    output logic fault_n_o // fault input, low when tripped
);
    // levels move just after an edge, as a real comparator would
    always_ff @(posedge clk_i) begin
        comparator1_o <= cause_i[0];
        comparator2_o <= cause_i[1];
        fault_n_o <= ~cause_i[2]; // active low fault
    end
endmodule

// ===== tb/ccp_enhanced_pwm_shutdown_tb_top.sv
// self-checking bench for the enhanced pwm shutdown unit
`timescale 1ns/1ps
module ccp_enhanced_pwm_shutdown_tb_top;
    logic clk_i = 0, reset_i = 1, wr = 0, rd = 0, rd_seen = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [2:0] cause = 3'h0;
    logic [31:0] seed = 32'h1461, noise = 32'h1461;
    logic c1, c2, flt_n, a, a_n, b, b_n, c, c_n, d, d_n;
    logic trst, adc, pri, alt;
    logic [15:0] first_timer = 16'h0000, v = 16'h0000;
    logic [7:0] exp_q[$];
    int bad_count = 0, comparisons = 0, n = 0;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    ccp_unit i_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .first_timer_i(first_timer),
        .first_timer_async_i(noise[16]), .second_timer_i(noise[24:17]),
        .second_timer_match_i(noise[25]), .second_module_pin_select_i(1'b1),
        .first_capture_pin_i(noise[26]), .second_primary_pin_i(noise[27]),
        .second_alternate_pin_i(noise[28]), .comparator1_i(c1),
        .comparator2_i(c2), .fault_input_n_i(flt_n),
        .first_timer_reset_o(trst), .adc_start_o(adc),
        .primary_output_pin_o(pri), .alternate_output_pin_o(alt),
        .pwm_out_a_o(a), .pwm_out_a_oe_n_o(a_n),
        .pwm_out_b_o(b), .pwm_out_b_oe_n_o(b_n), .pwm_out_c_o(c),
        .pwm_out_c_oe_n_o(c_n), .pwm_out_d_o(d), .pwm_out_d_oe_n_o(d_n));
    bridge_partner i_far (.clk_i(clk_i), .cause_i(cause),
        .comparator1_o(c1), .comparator2_o(c2), .fault_n_o(flt_n));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // capture inputs wander; first timer counts so hits can be scheduled
    always @(posedge clk_i) begin
        noise <= lfsr(noise);
        first_timer <= first_timer + 16'h0001;
        rd_seen <= rd;
    end
    // read data stands only in the cycle after the strobe
    always @(negedge clk_i) begin
        if (rd_seen) begin
            check(rdata, exp_q.pop_front());
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] ad, input logic [7:0] v);
        @(posedge clk_i);
        addr <= ad;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] ad, input logic [7:0] v);
        @(posedge clk_i);
        addr <= ad;
        rd <= 1'b1;
        exp_q.push_back(v);
        @(posedge clk_i);
        rd <= 1'b0;
    endtask
    // arm the second module a known distance ahead of the first timer
    task automatic arm(input logic [7:0] md);
        v = first_timer + 16'h0040;
        wr_reg(ccp_pkg::ADDR_SECOND_LOW, v[7:0]);
        wr_reg(ccp_pkg::ADDR_SECOND_HIGH, v[15:8]);
        wr_reg(ccp_pkg::ADDR_SECOND_CTRL, md);
        // bounded wait; outputs are looked at once settled after the edge
        for (n = 0; n < 100 && !(adc || pri); n++) begin
            @(posedge clk_i);
            #1;
        end
    endtask
    task automatic close_out();
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // overall hang guard
    initial begin
        repeat (50000) @(posedge clk_i);
        bad_count++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        rd_reg(ccp_pkg::ADDR_DEADBAND_RESTART, 8'h00);
        rd_reg(ccp_pkg::ADDR_SHUTDOWN_CONTROL, 8'h00);
        rd_reg(4'h9, 8'h00);
        // both bytes of the data value hold random values independently
        repeat (4) begin
            seed = lfsr(lfsr(seed));
            wr_reg(ccp_pkg::ADDR_FIRST_LOW, seed[7:0]);
            wr_reg(ccp_pkg::ADDR_FIRST_HIGH, seed[15:8]);
            rd_reg(ccp_pkg::ADDR_FIRST_LOW, seed[7:0]);
            rd_reg(ccp_pkg::ADDR_FIRST_HIGH, seed[15:8]);
        end
        // fault source, pair ac high, pair bd tri-state; mode still off
        wr_reg(ccp_pkg::ADDR_SHUTDOWN_CONTROL, 8'h46);
        cause <= 3'h4;
        repeat (2) @(posedge clk_i);
        #1 check({7'h00, a_n}, 8'h01);
        cause <= 3'h0;
        repeat (8) @(posedge clk_i);
        wr_reg(ccp_pkg::ADDR_SHUTDOWN_CONTROL, 8'h46);
        wr_reg(ccp_pkg::ADDR_FIRST_CTRL, 8'h06);
        repeat (4) @(posedge clk_i);
        cause <= 3'h4;
        @(posedge clk_i);
        #1 check({2'h0, a, a_n, c, c_n, b_n, d_n}, 8'h2B);
        repeat (8) @(posedge clk_i);
        rd_reg(ccp_pkg::ADDR_SHUTDOWN_CONTROL, 8'hC6);
        wr_reg(ccp_pkg::ADDR_SHUTDOWN_CONTROL, 8'h46);
        rd_reg(ccp_pkg::ADDR_SHUTDOWN_CONTROL, 8'hC6);
        // cause gone, no auto restart: firmware must clear the status
        cause <= 3'h0;
        repeat (8) @(posedge clk_i);
        rd_reg(ccp_pkg::ADDR_SHUTDOWN_CONTROL, 8'hC6);
        wr_reg(ccp_pkg::ADDR_SHUTDOWN_CONTROL, 8'h46);
        rd_reg(ccp_pkg::ADDR_SHUTDOWN_CONTROL, 8'h46);
        cause <= 3'h4;
        repeat (8) @(posedge clk_i);
        wr_reg(ccp_pkg::ADDR_DEADBAND_RESTART, 8'h80);
        cause <= 3'h0;
        repeat (8) @(posedge clk_i);
        rd_reg(ccp_pkg::ADDR_SHUTDOWN_CONTROL, 8'h46);
        rd_reg(ccp_pkg::ADDR_DEADBAND_RESTART, 8'h80);
        // special event: timer reset and conversion start together
        arm(8'h04);
        check({6'h00, trst, adc}, 8'h03);
        // toggle shows on the primary pin only; direction is software's
        arm(8'h03);
        check({6'h00, pri, alt}, 8'h02);
        repeat (4) @(posedge clk_i);
        close_out();
    end
endmodule
